// ### acps_chk.sv
`timescale 1ns/1ps
module acps_chk
#(
  parameter int PLL_START_CYCLES = 16
)
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       ratio_strap_low,
  input wire logic       ratio_strap_high,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_bvalid,
  input wire logic [1:0] clock_ratio_code,
  input wire logic       pll_locked,
  input wire logic       boot_done,
  input wire logic [6:0] in_gain,
  input wire logic [6:0] out_gain,
  input wire logic       datapath_clear,
  input wire logic       adc_powerdown,
  input wire logic [3:0] dac_powerdown,
  input wire logic       reference_powerdown,
  input wire logic       crystal_drive_enable
);
  logic [19:0] up_cnt_ff;
  logic [1:0]  pins_ff;
  logic [1:0]  steady_ff;
  wire  [1:0]  pins = {ratio_strap_high, ratio_strap_low};
  // Strap history only matters while reset is low
  always_ff @(posedge aclk)
  begin
    up_cnt_ff <= !aresetn ? 20'h0 : up_cnt_ff + 20'(up_cnt_ff != 20'hFFFFF);
    if (!aresetn)
    begin
      pins_ff   <= pins;
      steady_ff <= (pins !== pins_ff) ? 2'h0 : steady_ff + 2'(steady_ff != 2'h3);
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_release;
    $rose(aresetn);
  endsequence
  sequence s_steady;
    steady_ff == 2'h3;
  endsequence
  AST_RESET_OUT: assert property (s_release |-> crystal_drive_enable && datapath_clear
    && !adc_powerdown && dac_powerdown == 4'h0 && !reference_powerdown && !s_axi_bvalid)
    else $error("outputs not at reset state at release");
  AST_RATIO_CAP: assert property (s_release ##0 s_steady |=> clock_ratio_code == pins_ff)
    else $error("ratio not taken from straps at release");
  AST_RATIO_HOLD: assert property (aresetn && $past(aresetn, 2) |-> $stable(clock_ratio_code))
    else $error("ratio changed outside reset");
  AST_EARLY_WR: assert property (s_axi_bvalid && !boot_done |-> s_axi_bresp == acps_pkg::RESP_SLVERR)
    else $error("write accepted before start-up done");
  AST_PLL_TIME: assert property ($rose(pll_locked) |-> up_cnt_ff >= PLL_START_CYCLES
    && up_cnt_ff <= PLL_START_CYCLES + 2)
    else $error("pll start-up length wrong");
  AST_BOOT_LEN: assert property ($rose(boot_done) |-> $past(pll_locked, 63))
    else $error("boot shorter than expected");
  AST_OUT_STEP: assert property (boot_done && $past(boot_done) && $changed(out_gain)
    |-> out_gain == $past(out_gain) + 7'h1 || out_gain + 7'h1 == $past(out_gain))
    else $error("output gain jumped");
  AST_IN_STEP: assert property (boot_done && $past(boot_done) && $changed(in_gain)
    |-> in_gain == $past(in_gain) + 7'h1 || in_gain + 7'h1 == $past(in_gain))
    else $error("input gain jumped");
  AST_CLEAR_START: assert property (!pll_locked |-> datapath_clear)
    else $error("datapath not cleared during start-up");
endmodule // acps_chk
bind acps_top acps_chk #(.PLL_START_CYCLES(PLL_START_CYCLES)) i_chk (.aclk, .aresetn,
  .ratio_strap_low, .ratio_strap_high, .s_axi_bresp, .s_axi_bvalid, .clock_ratio_code,
  .pll_locked, .boot_done, .in_gain, .out_gain, .datapath_clear, .adc_powerdown,
  .dac_powerdown, .reference_powerdown, .crystal_drive_enable);

// ### acps_pkg.sv
package acps_pkg;
  localparam logic [11:0] ADDR_CORE_CTRL = 12'h000;
  localparam logic [11:0] ADDR_OUT_PORT  = 12'h004;
  localparam logic [11:0] ADDR_MP_CFG    = 12'h008;
  localparam logic [11:0] ADDR_POWER     = 12'h00C;
  localparam logic [11:0] ADDR_OSC_PD    = 12'h010;
  localparam logic [11:0] ADDR_STATUS    = 12'h014;
  // Printed register indices, kept for reference
  localparam int IDX_OUT_PORT = 2078;
  localparam int IDX_MP_CFG   = 2081;
  // Core control fields
  localparam int CC_CLEAR_BIT   = 2;
  localparam int CC_MUTE_IN_BIT = 3;
  localparam int CC_MUTE_OUT_BIT = 4;
  localparam int CC_RATE_LSB    = 5;
  // Output port fields
  localparam int OP_DIV_LSB    = 0;
  localparam int OP_MASTER_BIT = 2;
  // Multipurpose pin eleven function field
  localparam int MULTIPURPOSE_PIN_ELEVEN_FUNC_LSB = 0;
  localparam logic [3:0] MULTIPURPOSE_PIN_ELEVEN_FUNC_BITCLK = 4'h1;
  // Power fields
  localparam int PW_ADC_BIT   = 0;
  localparam int PW_DAC_LSB   = 1;
  localparam int PW_REF_A_BIT = 6;
  localparam int PW_REF_B_BIT = 7;
  localparam int OSC_PD_BIT   = 0;
  localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
  // Timing
  localparam int PLL_START_CYCLES = 262144;
  localparam int RAMP_STEPS       = 64;
  localparam int BOOT_CYCLES      = 64;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### acps_ramp.sv
`timescale 1ns/1ps
// Gradual volume ramp; gain steps toward 0 when muted, toward full when released
module acps_ramp
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       mute,
  output logic [6:0]      gain
);
  logic [6:0] gain_ff;
  logic [6:0] nxt_gain;
  localparam logic [6:0] FULL = 7'(acps_pkg::RAMP_STEPS);
  assign nxt_gain = mute ? ((gain_ff != 7'h00) ? gain_ff - 7'h01 : gain_ff)
                         : ((gain_ff != FULL) ? gain_ff + 7'h01 : gain_ff);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      gain_ff <= FULL;
    else
      gain_ff <= nxt_gain;
  end
  assign gain = gain_ff;
endmodule // acps_ramp

// ### acps_strap_src.sv
`timescale 1ns/1ps
module acps_strap_src
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       rogue,
  input  wire logic [1:0] want,
  output logic            ratio_strap_low,
  output logic            ratio_strap_high
);
  logic [1:0] held_ff = 2'h0;
  // Misbehaves only when a scenario raises rogue
  wire        apply = !aresetn || rogue;
  wire  [1:0] pins  = apply ? want : held_ff;
  assign ratio_strap_low  = pins[0];
  assign ratio_strap_high = pins[1];
  always_ff @(posedge aclk) held_ff <= pins;
endmodule // acps_strap_src

// ### acps_top.sv
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module acps_top
#(
  parameter int PLL_START_CYCLES = acps_pkg::PLL_START_CYCLES
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ratio_strap_low,
  input  wire logic        ratio_strap_high,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [1:0]       clock_ratio_code,
  output logic             pll_locked,
  output logic             boot_done,
  output logic [6:0]       in_gain,
  output logic [6:0]       out_gain,
  output logic             datapath_clear,
  output logic             adc_powerdown,
  output logic [3:0]       dac_powerdown,
  output logic             reference_powerdown,
  output logic             crystal_drive_enable,
  output logic             multipurpose_pin_eleven,
  output logic             multipurpose_pin_eleven_oe
);
  typedef enum logic [1:0] {ST_PLL, ST_BOOT, ST_RUN} acps_state_e;

  function automatic logic hit(input logic [31:0] a, input logic [11:0] off);
    hit = (a[11:0] == off) && (a[31:12] == 20'h00000);
  endfunction

  // Strap synchronisers; second stage alone is read
  logic [1:0] strap_s1_ff;
  logic [1:0] strap_s2_ff;
  logic [1:0] ratio_ff;
  logic       rst_seen_ff;
  always_ff @(posedge aclk)
  begin
    strap_s1_ff <= {ratio_strap_high, ratio_strap_low};
    strap_s2_ff <= strap_s1_ff;
  end

  // Ratio tracks straps during reset, frozen from release on
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ratio_ff    <= strap_s2_ff;
      rst_seen_ff <= 1'b0;
    end
    else
      rst_seen_ff <= 1'b1;
  end

  // Start-up: PLL lock count then boot load
  acps_state_e state_ff;
  acps_state_e nxt_state;
  logic [18:0] cnt_ff;
  logic [18:0] nxt_cnt;
  wire         cnt_end = (state_ff == ST_PLL) ? (cnt_ff == 19'(PLL_START_CYCLES - 1))
                                               : (cnt_ff == 19'(acps_pkg::BOOT_CYCLES - 1));
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff + 19'h00001;
    case (state_ff)
      ST_PLL:
        if (cnt_end)
        begin
          nxt_state = ST_BOOT;
          nxt_cnt   = 19'h00000;
        end
      ST_BOOT:
        if (cnt_end)
        begin
          nxt_state = ST_RUN;
          nxt_cnt   = 19'h00000;
        end
      ST_RUN:  nxt_cnt = cnt_ff;
      default: nxt_state = ST_PLL;
    endcase
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_ff <= ST_PLL;
      cnt_ff   <= 19'h00000;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end
  wire ready = (state_ff == ST_RUN);

  // Registers
  logic [31:0] core_ff;
  logic [31:0] outp_ff;
  logic [31:0] mpcfg_ff;
  logic [31:0] power_ff;
  logic [31:0] oscpd_ff;

  // AXI write: address and data latched in either order
  logic        aw_ok_ff;
  logic        w_ok_ff;
  logic [31:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  // Ready comes from a flop like every other port; costs one cycle per request
  logic        awready_ff;
  logic        wready_ff;
  wire nxt_awready = s_axi_awvalid && !aw_ok_ff && !bvalid_ff && !awready_ff;
  wire nxt_wready  = s_axi_wvalid && !w_ok_ff && !bvalid_ff && !wready_ff;
  wire aw_take     = s_axi_awvalid && awready_ff;
  wire w_take      = s_axi_wvalid && wready_ff;
  wire do_wr   = aw_ok_ff && w_ok_ff && !bvalid_ff;
  wire wr_core = hit(awaddr_ff, acps_pkg::ADDR_CORE_CTRL);
  wire wr_outp = hit(awaddr_ff, acps_pkg::ADDR_OUT_PORT);
  wire wr_mp   = hit(awaddr_ff, acps_pkg::ADDR_MP_CFG);
  wire wr_pw   = hit(awaddr_ff, acps_pkg::ADDR_POWER);
  wire wr_osc  = hit(awaddr_ff, acps_pkg::ADDR_OSC_PD);
  wire wr_any  = wr_core || wr_outp || wr_mp || wr_pw || wr_osc;
  // Writes during start-up are refused: registers are being initialised
  wire wr_en   = do_wr && wr_any && ready;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++)
      merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
  endfunction

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_ok_ff  <= 1'b0;
      w_ok_ff   <= 1'b0;
      awaddr_ff <= 32'h0000_0000;
      wdata_ff  <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= acps_pkg::RESP_OKAY;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
    end
    else
    begin
      awready_ff <= nxt_awready;
      wready_ff  <= nxt_wready;
      if (aw_take)
      begin
        aw_ok_ff  <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_take)
      begin
        w_ok_ff  <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (do_wr)
      begin
        aw_ok_ff  <= 1'b0;
        w_ok_ff   <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_en ? acps_pkg::RESP_OKAY : acps_pkg::RESP_SLVERR;
      end
      else if (bvalid_ff && s_axi_bready)
        bvalid_ff <= 1'b0;
    end
  end

  // Register file; all clear to zero on reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      core_ff  <= acps_pkg::RESET_VALUE;
      outp_ff  <= acps_pkg::RESET_VALUE;
      mpcfg_ff <= acps_pkg::RESET_VALUE;
      power_ff <= acps_pkg::RESET_VALUE;
      oscpd_ff <= acps_pkg::RESET_VALUE;
    end
    else if (wr_en)
    begin
      if (wr_core) core_ff  <= merge(core_ff, wdata_ff, wstrb_ff);
      if (wr_outp) outp_ff  <= merge(outp_ff, wdata_ff, wstrb_ff);
      if (wr_mp)   mpcfg_ff <= merge(mpcfg_ff, wdata_ff, wstrb_ff);
      if (wr_pw)   power_ff <= merge(power_ff, wdata_ff, wstrb_ff);
      if (wr_osc)  oscpd_ff <= merge(oscpd_ff, wdata_ff, wstrb_ff);
    end
  end

  // AXI read
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic        arready_ff;
  logic [6:0]  in_gain_w;
  logic [6:0]  out_gain_w;
  wire nxt_arready = s_axi_arvalid && !rvalid_ff && !arready_ff;
  wire ar_take     = s_axi_arvalid && arready_ff;
  wire [31:0] status_word = {24'h000000, out_gain_w == 7'h00, in_gain_w == 7'h00,
                             rst_seen_ff, ready, state_ff != ST_PLL, 1'b0, ratio_ff};
  logic [31:0] rd_mux;
  logic        rd_hit;
  always_comb
  begin
    rd_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr[11:0])
      acps_pkg::ADDR_CORE_CTRL: rd_mux = core_ff;
      acps_pkg::ADDR_OUT_PORT:  rd_mux = outp_ff;
      acps_pkg::ADDR_MP_CFG:    rd_mux = mpcfg_ff;
      acps_pkg::ADDR_POWER:     rd_mux = power_ff;
      acps_pkg::ADDR_OSC_PD:    rd_mux = oscpd_ff;
      acps_pkg::ADDR_STATUS:    rd_mux = status_word;
      default:                  rd_hit = 1'b0;
    endcase
    if (s_axi_araddr[31:12] != 20'h00000)
      rd_hit = 1'b0;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= acps_pkg::RESP_OKAY;
      arready_ff <= 1'b0;
    end
    else
    begin
      arready_ff <= nxt_arready;
      if (ar_take)
      begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= rd_hit ? rd_mux : 32'h0000_0000;
        rresp_ff  <= rd_hit ? acps_pkg::RESP_OKAY : acps_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
        rvalid_ff <= 1'b0;
    end
  end

  // Mute ramps
  acps_ramp u_in_ramp
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .mute    (core_ff[acps_pkg::CC_MUTE_IN_BIT]),
    .gain    (in_gain_w)
  );
  acps_ramp u_out_ramp
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .mute    (core_ff[acps_pkg::CC_MUTE_OUT_BIT]),
    .gain    (out_gain_w)
  );

  // Bit clock divider for pin eleven: divide by 2^(sel+1)
  logic [3:0] div_ff;
  wire [1:0] div_sel = outp_ff[acps_pkg::OP_DIV_LSB +: 2];
  wire       multipurpose_pin_eleven_on = (mpcfg_ff[acps_pkg::MULTIPURPOSE_PIN_ELEVEN_FUNC_LSB +: 4] == acps_pkg::MULTIPURPOSE_PIN_ELEVEN_FUNC_BITCLK)
                       && outp_ff[acps_pkg::OP_MASTER_BIT];
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      div_ff <= 4'h0;
    else
      div_ff <= div_ff + 4'h1;
  end

  // Registered outputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      in_gain                    <= 7'h00;
      out_gain                   <= 7'h00;
      datapath_clear             <= 1'b1;
      adc_powerdown              <= 1'b0;
      dac_powerdown              <= 4'h0;
      reference_powerdown        <= 1'b0;
      crystal_drive_enable       <= 1'b1;
      multipurpose_pin_eleven    <= 1'b0;
      multipurpose_pin_eleven_oe <= 1'b0;
      pll_locked                 <= 1'b0;
      boot_done                  <= 1'b0;
      clock_ratio_code           <= 2'h0;
    end
    else
    begin
      in_gain                    <= in_gain_w;
      out_gain                   <= out_gain_w;
      datapath_clear             <= core_ff[acps_pkg::CC_CLEAR_BIT] || !ready;
      adc_powerdown              <= power_ff[acps_pkg::PW_ADC_BIT];
      dac_powerdown              <= power_ff[acps_pkg::PW_DAC_LSB +: 4];
      reference_powerdown        <= power_ff[acps_pkg::PW_REF_A_BIT]
                                    && power_ff[acps_pkg::PW_REF_B_BIT];
      crystal_drive_enable       <= !oscpd_ff[acps_pkg::OSC_PD_BIT];
      multipurpose_pin_eleven    <= multipurpose_pin_eleven_on && div_ff[div_sel];
      multipurpose_pin_eleven_oe <= multipurpose_pin_eleven_on;
      pll_locked                 <= state_ff != ST_PLL;
      boot_done                  <= ready;
      clock_ratio_code           <= ratio_ff;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
endmodule // acps_top

// ### tb_audio_core_clock_power_setup.sv
`timescale 1ns/1ps
module tb_audio_core_clock_power_setup;
  logic aclk = 1'b0, aresetn = 1'b0, rogue = 1'b0, ratio_strap_low, ratio_strap_high;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, pll_locked, boot_done;
  logic datapath_clear, adc_powerdown, reference_powerdown, crystal_drive_enable;
  logic multipurpose_pin_eleven, multipurpose_pin_eleven_oe;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, v, p;
  logic [3:0]  s_axi_wstrb, dac_powerdown;
  logic [1:0]  s_axi_bresp, s_axi_rresp, clock_ratio_code, want, code;
  logic [6:0]  in_gain, out_gain;
  logic [33:0] e, bq[$], rq[$];
  logic [31:0] pv[7];
  int n_fail = 0, total_checks = 0;
  always #10 aclk = ~aclk;
  acps_top #(.PLL_START_CYCLES(16)) i_dut (.aclk, .aresetn, .ratio_strap_low, .ratio_strap_high,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .clock_ratio_code, .pll_locked, .boot_done, .in_gain, .out_gain, .datapath_clear,
    .adc_powerdown, .dac_powerdown, .reference_powerdown, .crystal_drive_enable,
    .multipurpose_pin_eleven, .multipurpose_pin_eleven_oe);
  acps_strap_src i_src (.aclk, .aresetn, .rogue, .want, .ratio_strap_low, .ratio_strap_high);
  task finish_test();
    if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk_word(input string nm, input logic [31:0] ex, input logic [31:0] got);
    total_checks++;
    if (got !== ex)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task chk_resp(input string nm, input logic [1:0] ex, input logic [1:0] got);
    chk_word(nm, 32'(ex), 32'(got));
  endtask
  task axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    bit aw_ok, w_ok;
    bq.push_back({r, 32'h0});
    aw_ok = 0;
    w_ok = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1)
      begin
        aw_ok = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1)
      begin
        w_ok = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task axi_rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    rq.push_back({r, d});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
  task do_reset(input logic [1:0] c);
    @(posedge aclk);
    want <= c;
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk_word("ratio", 32'(c), 32'(clock_ratio_code));
  endtask
  // Results of bus transfers are judged where they appear
  always @(posedge aclk)
  begin
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1 && bq.size() > 0)
    begin
      e = bq.pop_front();
      chk_resp("bresp", e[33:32], s_axi_bresp);
    end
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1 && rq.size() > 0)
    begin
      e = rq.pop_front();
      chk_resp("rresp", e[33:32], s_axi_rresp);
      chk_word("rdata", e[31:0], s_axi_rdata);
    end
  end
  initial
  begin
    #400000;
    n_fail++;
    finish_test();
  end
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'hF;
    void'($urandom(32'hfb3c));
    code = 2'($urandom);
    want = code;
    // Reference goes down only after every converter is already down
    pv = '{32'h1F, 32'hDF, 32'h9F, 32'h40, 32'h0, 32'h0, 32'h0};
    pv[4] = $urandom & 32'h3F;
    pv[5] = $urandom & 32'h3F;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk_word("ratio", 32'(code), 32'(clock_ratio_code));
    axi_wr(32'(acps_pkg::ADDR_POWER), 32'h1, acps_pkg::RESP_SLVERR);
    chk_word("adc_pd", 32'h0, 32'(adc_powerdown));
    for (int i = 0; i < 1000 && boot_done !== 1'b1; i++) @(posedge aclk);
    chk_word("boot_done", 32'h1, 32'(boot_done));
    chk_word("xtal_en", 32'h1, 32'(crystal_drive_enable));
    for (int a = 0; a < 20; a += 4) axi_rd(32'(a), 32'h0, acps_pkg::RESP_OKAY);
    axi_rd(32'h20, 32'h0, acps_pkg::RESP_SLVERR);
    axi_wr(32'h20, 32'hFFFFFFFF, acps_pkg::RESP_SLVERR);
    axi_rd(32'(acps_pkg::ADDR_STATUS), 32'h38 | 32'(code), acps_pkg::RESP_OKAY);
    foreach (pv[i])
    begin
      v = pv[i];
      axi_wr(32'(acps_pkg::ADDR_POWER), v, acps_pkg::RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk_word("adc_pd", 32'(v[0]), 32'(adc_powerdown));
      chk_word("dac_pd", 32'(v[4:1]), 32'(dac_powerdown));
      chk_word("ref_pd", 32'(v[6] & v[7]), 32'(reference_powerdown));
      axi_rd(32'(acps_pkg::ADDR_POWER), v, acps_pkg::RESP_OKAY);
    end
    axi_wr(32'(acps_pkg::ADDR_OSC_PD), 32'h1, acps_pkg::RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk_word("xtal_en", 32'h0, 32'(crystal_drive_enable));
    axi_wr(32'(acps_pkg::ADDR_CORE_CTRL), 32'h10, acps_pkg::RESP_OKAY);
    repeat (70) @(posedge aclk);
    chk_word("out_gain", 32'h0, 32'(out_gain));
    chk_word("in_gain", 32'h40, 32'(in_gain));
    axi_wr(32'(acps_pkg::ADDR_CORE_CTRL), 32'h18, acps_pkg::RESP_OKAY);
    repeat (70) @(posedge aclk);
    chk_word("in_gain", 32'h0, 32'(in_gain));
    axi_rd(32'(acps_pkg::ADDR_STATUS), 32'hF8 | 32'(code), acps_pkg::RESP_OKAY);
    axi_wr(32'(acps_pkg::ADDR_CORE_CTRL), 32'h1C, acps_pkg::RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk_word("clear", 32'h1, 32'(datapath_clear));
    axi_wr(32'(acps_pkg::ADDR_CORE_CTRL), 32'h0, acps_pkg::RESP_OKAY);
    repeat (70) @(posedge aclk);
    chk_word("clear", 32'h0, 32'(datapath_clear));
    chk_word("gains", {18'h0, 7'(acps_pkg::RAMP_STEPS), 7'(acps_pkg::RAMP_STEPS)},
             {18'h0, in_gain, out_gain});
    // Rate field is only stored; matching the supplied clock ratio is the host's duty
    for (int k = 1; k < 3; k++)
    begin
      v = 32'(k) << acps_pkg::CC_RATE_LSB;
      axi_wr(32'(acps_pkg::ADDR_CORE_CTRL), v, acps_pkg::RESP_OKAY);
      axi_rd(32'(acps_pkg::ADDR_CORE_CTRL), v, acps_pkg::RESP_OKAY);
    end
    axi_wr(32'(acps_pkg::ADDR_MP_CFG), 32'(acps_pkg::MULTIPURPOSE_PIN_ELEVEN_FUNC_BITCLK), acps_pkg::RESP_OKAY);
    for (int s = 0; s < 4; s++)
    begin
      axi_wr(32'(acps_pkg::ADDR_OUT_PORT), 32'h4 | 32'(s), acps_pkg::RESP_OKAY);
      repeat (8) @(posedge aclk);
      while (multipurpose_pin_eleven !== 1'b0) @(posedge aclk);
      while (multipurpose_pin_eleven !== 1'b1) @(posedge aclk);
      p = 0;
      do
      begin
        @(posedge aclk);
        p++;
      end
      while (multipurpose_pin_eleven !== 1'b0);
      chk_word("multipurpose_pin_eleven_half", 32'h1 << s, p);
      chk_word("multipurpose_pin_eleven_oe", 32'h1, 32'(multipurpose_pin_eleven_oe));
    end
    // Straps wiggle in mid-run; the captured ratio must not follow
    want <= ~code;
    rogue <= 1'b1;
    repeat (10) @(posedge aclk);
    chk_word("ratio", 32'(code), 32'(clock_ratio_code));
    rogue <= 1'b0;
    for (int c = 0; c < 4; c++)
    begin
      do_reset(2'(c));
      axi_rd(32'(acps_pkg::ADDR_STATUS), 32'h20 | 32'(c), acps_pkg::RESP_OKAY);
    end
    finish_test();
  end
endmodule // tb_audio_core_clock_power_setup
